// ### hw/mcp_pkg.sv
// Constants and types for the core operating-state controller
`default_nettype none
package mcp_pkg;
    // Clock rate of the device clock
    localparam int CLK_FREQ_MHZ = 50;
    // Reference settling wait, least time, in microseconds
    localparam int REF_SETTLE_TIME_US = 4;
    localparam int REF_SETTLE_CYC = REF_SETTLE_TIME_US * CLK_FREQ_MHZ;
    // Sleep timeout (watchdog period), longest time, in milliseconds
    localparam int SLEEP_TIMEOUT_MS = 2000;
    localparam int SLEEP_TIMEOUT_CYC = SLEEP_TIMEOUT_MS * CLK_FREQ_MHZ * 1000;
    // Timer counter width
    localparam int TMR_W = 32;
    // Command kind field
    localparam int CMD_KIND_W = 2;
    localparam logic [1:0] CMD_CONVERT = 2'h0;
    localparam logic [1:0] CMD_DIAGNOSE = 2'h1;
    localparam logic [1:0] CMD_WRITE_CONFIG_GROUP_A = 2'h2;
    localparam logic [1:0] CMD_OTHER = 2'h3;
    // Reset value of the reference-keep-on bit
    localparam logic REF_KEEP_ON_RST = 1'h0;
    // Core states, one-hot
    localparam int STATE_W = 5;
    typedef enum logic [4:0] {
        ST_SLEEP = 5'h01,
        ST_STANDBY = 5'h02,
        ST_SETTLE = 5'h04,
        ST_REF_UP = 5'h08,
        ST_MEASURE = 5'h10
    } mcp_state_t;
endpackage
`default_nettype wire

// ### hw/mcp_sync.sv
// Two-flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module mcp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// ### hw/mcp_timer.sv
// Restartable down-counter with expiry level
`timescale 1ns/1ps
`default_nettype none
module mcp_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic restart,
    input wire logic [W-1:0] load,
    // Status
    output logic expired
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // Reload on restart, else count down and stop at zero
    always_comb begin
        next_count = count;
        if (restart) begin
            next_count = load;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    // Starts expired so the core wakes into sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign expired = (count == '0);
endmodule
`default_nettype wire

// ### hw/mcp_core_power.sv
// Core operating-state controller: sleep, standby, reference-up, measure
// Function
// - Sleep: reference and converters off, serial ports idle, regulator drive low.
// - Sleep only when watchdog expired and discharge timer disabled or expired.
// - Wake-up signal in sleep moves the core to standby.
// - Standby: reference and converters off, regulator drive enabled.
// - Conversion command or keep-on set in standby: settle reference, then advance.
// - Standby returns to sleep once both timers have expired.
// - Discharge timer disabled: watchdog alone decides standby to sleep.
// - Reference-up: converters off, reference powered, no settling on next conversion.
// - Reference-up plus conversion command enters measure and starts conversion.
// - Reference-up returns to standby when a write clears keep-on.
// - Watchdog expiry clears keep-on; with discharge expired, go straight to sleep.
// - Measure powers reference and converters and runs the conversions.
// - Conversions done: reference-up if keep-on set, otherwise standby.
// - Only conversion or diagnostic commands enter measure; a write to keep-on also changes state.
`timescale 1ns/1ps
`default_nettype none
module mcp_core_power #(
    parameter int SLEEP_TIMEOUT_CYC = mcp_pkg::SLEEP_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Wake-up from the serial ports, asynchronous pin
    input wire logic WAKE_PIN,
    // Decoded command from the serial link
    input wire logic CMD_VALID,
    input wire logic [mcp_pkg::CMD_KIND_W-1:0] CMD_KIND,
    input wire logic CMD_REF_KEEP_ON,
    // Converter and discharge timer status
    input wire logic CONV_DONE,
    input wire logic DISCHARGE_ENABLE,
    input wire logic DISCHARGE_EXPIRED,
    // Power controls
    output logic REF_POWER_ON,
    output logic ADC_POWER_ON,
    output logic SERIAL_PORTS_IDLE,
    output logic REGULATOR_DRIVE_EN,
    // Status
    output logic CONV_START,
    output logic REFERENCE_KEEP_ON,
    output logic WATCHDOG_EXPIRED,
    output logic [mcp_pkg::STATE_W-1:0] CORE_STATE
);
    import mcp_pkg::*;

    localparam logic [TMR_W-1:0] SETTLE_LOAD = TMR_W'(REF_SETTLE_CYC);
    localparam logic [TMR_W-1:0] SLEEP_LOAD = TMR_W'(SLEEP_TIMEOUT_CYC);

    logic rst_meta;
    logic rst_n;
    logic wake;
    logic wd_expired;
    logic wd_expired_q;
    logic wd_fire;
    logic settle_done;
    logic conv_cmd;
    logic cfg_write;
    logic sleep_ok;
    logic wd_restart;
    logic settle_restart;
    mcp_state_t state;
    mcp_state_t next_state;
    logic reference_keep_on;
    logic next_keep_on;
    logic conv_pending;
    logic next_pending;

    // Reset released through two flops, asserted at once
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Wake pin comes from the link side, so synchronise it
    mcp_sync #(.W(1)) u_wake_sync (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .d(WAKE_PIN),
        .q(wake)
    );

    // Command decode; commands are ignored while ports are idle
    assign conv_cmd = CMD_VALID && (state != ST_SLEEP)
        && (CMD_KIND == CMD_CONVERT || CMD_KIND == CMD_DIAGNOSE);
    assign cfg_write = CMD_VALID && (state != ST_SLEEP)
        && (CMD_KIND == CMD_WRITE_CONFIG_GROUP_A);
    // Discharge timer counts only while enabled; a command vetoes sleep
    assign sleep_ok = wd_expired && !wd_restart
        && (!DISCHARGE_ENABLE || DISCHARGE_EXPIRED);

    // Watchdog reloads on traffic, and on wake so standby is not left at once
    assign wd_restart = (CMD_VALID && state != ST_SLEEP)
        || (state == ST_SLEEP && wake);
    mcp_timer #(.W(TMR_W)) u_watchdog (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .restart(wd_restart),
        .load(SLEEP_LOAD),
        .expired(wd_expired)
    );

    // Settling timer loads on the edge that enters the settle wait
    assign settle_restart = (next_state == ST_SETTLE) && (state != ST_SETTLE);
    mcp_timer #(.W(TMR_W)) u_settle (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .restart(settle_restart),
        .load(SETTLE_LOAD),
        .expired(settle_done)
    );

    // Expiry edge, so keep-on is cleared once rather than held low
    assign wd_fire = wd_expired && !wd_expired_q;

    // Keep-on bit: a write in the expiry cycle wins over the clear
    always_comb begin
        next_keep_on = reference_keep_on;
        if (cfg_write) begin
            next_keep_on = CMD_REF_KEEP_ON;
        end else if (wd_fire) begin
            next_keep_on = 1'b0;
        end
    end

    // Core state sequencing
    always_comb begin
        next_state = state;
        next_pending = conv_pending;
        unique case (state)
            ST_SLEEP: begin
                next_pending = 1'b0;
                if (wake) begin
                    next_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (conv_cmd) begin
                    next_state = ST_SETTLE;
                    next_pending = 1'b1;
                end else if (reference_keep_on) begin
                    next_state = ST_SETTLE;
                end else if (sleep_ok) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SETTLE: begin
                // A command during the wait is held until it ends
                if (conv_cmd) begin
                    next_pending = 1'b1;
                end
                if (settle_done) begin
                    if (conv_pending || conv_cmd) begin
                        next_state = ST_MEASURE;
                    end else if (reference_keep_on) begin
                        next_state = ST_REF_UP;
                    end else begin
                        next_state = ST_STANDBY;
                    end
                end
            end
            ST_REF_UP: begin
                if (conv_cmd) begin
                    next_state = ST_MEASURE;
                end else if (!reference_keep_on) begin
                    // Expiry with discharge expired skips standby
                    next_state = sleep_ok ? ST_SLEEP : ST_STANDBY;
                end
            end
            ST_MEASURE: begin
                next_pending = 1'b0;
                if (CONV_DONE) begin
                    next_state = reference_keep_on ? ST_REF_UP
                        : ST_STANDBY;
                end
            end
            default: begin
                next_state = ST_SLEEP;
                next_pending = 1'b0;
            end
        endcase
    end

    // State, keep-on and registered outputs
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SLEEP;
            conv_pending <= 1'b0;
            reference_keep_on <= REF_KEEP_ON_RST;
            wd_expired_q <= 1'b1;
            REF_POWER_ON <= 1'b0;
            ADC_POWER_ON <= 1'b0;
            SERIAL_PORTS_IDLE <= 1'b1;
            REGULATOR_DRIVE_EN <= 1'b0;
            CONV_START <= 1'b0;
        end else begin
            state <= next_state;
            conv_pending <= next_pending;
            reference_keep_on <= next_keep_on;
            wd_expired_q <= wd_expired;
            // Powers follow the state they are about to enter
            REF_POWER_ON <= (next_state == ST_SETTLE)
                || (next_state == ST_REF_UP)
                || (next_state == ST_MEASURE);
            ADC_POWER_ON <= (next_state == ST_MEASURE);
            SERIAL_PORTS_IDLE <= (next_state == ST_SLEEP);
            REGULATOR_DRIVE_EN <= (next_state != ST_SLEEP);
            CONV_START <= (next_state == ST_MEASURE)
                && (state != ST_MEASURE);
        end
    end

    // Status outputs from flops; watchdog expiry is decoded from its counter
    assign REFERENCE_KEEP_ON = reference_keep_on;
    assign WATCHDOG_EXPIRED = wd_expired;
    assign CORE_STATE = state;

    // Length of the current settle wait, for checking only
    logic [TMR_W-1:0] settle_len;
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            settle_len <= '0;
        end else begin
            settle_len <= (state == ST_SETTLE) ? settle_len + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    sleep_power_a: assert property (
        state == ST_SLEEP |-> !REF_POWER_ON && !ADC_POWER_ON
            && SERIAL_PORTS_IDLE && !REGULATOR_DRIVE_EN)
        else $error("sleep powers wrong");
    sleep_entry_a: assert property (
        $rose(state == ST_SLEEP) |-> $past(sleep_ok))
        else $error("sleep entered with timers running");
    wake_standby_a: assert property (
        state == ST_SLEEP && wake |=> state == ST_STANDBY)
        else $error("wake did not reach standby");
    standby_power_a: assert property (
        state == ST_STANDBY |-> !REF_POWER_ON && !ADC_POWER_ON
            && REGULATOR_DRIVE_EN)
        else $error("standby powers wrong");
    settle_time_a: assert property (
        $fell(state == ST_SETTLE) |-> settle_len == SETTLE_LOAD + 1'b1)
        else $error("settle wait length wrong");
    standby_sleep_a: assert property (
        state == ST_STANDBY && sleep_ok && !conv_cmd && !reference_keep_on
            |=> state == ST_SLEEP)
        else $error("standby missed sleep");
    wd_alone_a: assert property (
        state == ST_STANDBY && !DISCHARGE_ENABLE && wd_expired && !CMD_VALID
            && !conv_cmd && !reference_keep_on |=> state == ST_SLEEP)
        else $error("watchdog alone did not sleep");
    ref_up_power_a: assert property (
        state == ST_REF_UP |-> REF_POWER_ON && !ADC_POWER_ON)
        else $error("reference-up powers wrong");
    ref_up_measure_a: assert property (
        state == ST_REF_UP && conv_cmd |=> state == ST_MEASURE && CONV_START)
        else $error("conversion not started from reference-up");
    ref_up_drop_a: assert property (
        state == ST_REF_UP && !reference_keep_on && !conv_cmd
            |=> state == ST_STANDBY || state == ST_SLEEP)
        else $error("reference-up held without keep-on");
    wd_clear_a: assert property (
        wd_fire && !cfg_write |=> !reference_keep_on)
        else $error("expiry did not clear keep-on");
    measure_power_a: assert property (
        state == ST_MEASURE |-> REF_POWER_ON && ADC_POWER_ON)
        else $error("measure powers wrong");
    conv_finish_a: assert property (
        state == ST_MEASURE && CONV_DONE |=> state ==
            ($past(reference_keep_on) ? ST_REF_UP : ST_STANDBY))
        else $error("wrong state after conversion");
    measure_cause_a: assert property (
        $rose(state == ST_MEASURE) |-> $past(conv_cmd || conv_pending))
        else $error("measure entered without conversion");
    wd_restart_a: assert property (
        CMD_VALID && state != ST_SLEEP |=> !wd_expired ##1 !wd_expired)
        else $error("command did not restart watchdog");

    wake_cycle_c: cover property (
        state == ST_SLEEP ##1 state == ST_STANDBY [*2] ##[1:300]
        state == ST_SETTLE);
    ref_up_conv_c: cover property (
        state == ST_REF_UP ##1 state == ST_MEASURE);
    ref_up_sleep_c: cover property (
        state == ST_REF_UP ##1 state == ST_SLEEP);
    measure_done_c: cover property (
        state == ST_MEASURE && CONV_DONE);
endmodule
`default_nettype wire

// ### verification/mcp_host_model.sv
// Host command source and converter model facing the state controller
`timescale 1ns/1ps
`default_nettype none
module mcp_host_model (
    // Clock
    input wire logic clk,
    // Converter start from the controller
    input wire logic conv_start,
    // Command link towards the controller
    output logic cmd_valid,
    output logic [1:0] cmd_kind,
    output logic cmd_keep,
    // Converter completion
    output logic conv_done
);
    int delay = 1;
    int cnt = 0;

    // Quiet link at time zero
    initial begin
        cmd_valid = 1'h0;
        cmd_kind = 2'h3;
        cmd_keep = 1'h0;
        conv_done = 1'h0;
    end

    // One command; fields inverted once no longer qualified
    task automatic send(input logic [1:0] kind, input logic keep);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_kind <= kind;
        cmd_keep <= keep;
        @(posedge clk);
        cmd_valid <= 1'h0;
        cmd_kind <= ~kind;
        cmd_keep <= ~keep;
    endtask

    // Converter answers after a settable delay, fast or slow
    always @(posedge clk) begin
        conv_done <= 1'h0;
        if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                conv_done <= 1'h1;
            end
        end else if (conv_start === 1'h1) begin
            cnt <= delay;
        end
    end
endmodule
`default_nettype wire

// ### verification/mcp_core_power_tb.sv
// Testbench for the core operating-state controller
`timescale 1ns/1ps
`default_nettype none
module mcp_core_power_tb;
    import mcp_pkg::*;
    // Short watchdog so sleep cases finish quickly
    localparam int WD_CYC = 1000;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic wake_pin = 1'h0;
    logic dis_en = 1'h1;
    logic dis_exp = 1'h0;
    logic cmd_valid, cmd_keep, conv_done, conv_start;
    logic [1:0] cmd_kind;
    logic ref_on, adc_on, idle, drive, keep_on, wd_exp;
    logic [STATE_W-1:0] state;
    int n_mismatch = 0;
    int n_compared = 0;
    int n;

    always #10 clk_sys = ~clk_sys;

    mcp_core_power #(.SLEEP_TIMEOUT_CYC(WD_CYC)) mcp_core_power_i (
        .CLK_SYS(clk_sys), .RSTN(rstn), .WAKE_PIN(wake_pin),
        .CMD_VALID(cmd_valid), .CMD_KIND(cmd_kind),
        .CMD_REF_KEEP_ON(cmd_keep), .CONV_DONE(conv_done),
        .DISCHARGE_ENABLE(dis_en), .DISCHARGE_EXPIRED(dis_exp),
        .REF_POWER_ON(ref_on), .ADC_POWER_ON(adc_on),
        .SERIAL_PORTS_IDLE(idle), .REGULATOR_DRIVE_EN(drive),
        .CONV_START(conv_start), .REFERENCE_KEEP_ON(keep_on),
        .WATCHDOG_EXPIRED(wd_exp), .CORE_STATE(state));

    mcp_host_model mcp_host_model_i (
        .clk(clk_sys), .conv_start(conv_start), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_keep(cmd_keep), .conv_done(conv_done));

    // Verdict and end of run
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // Bounded wait; leaves the cycle count in n
    task automatic wait_state(input logic [4:0] s, input int lim);
        #1;
        n = 0;
        while (state !== s && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask

    task automatic t_wake;
        @(posedge clk_sys);
        wake_pin <= 1'h1;
        repeat (4) @(posedge clk_sys);
        wake_pin <= 1'h0;
        wait_state(ST_STANDBY, 10);
        check(state, ST_STANDBY);
        check({ref_on, adc_on, idle, drive}, 4'h1);
    endtask

    // Conversion or diagnostic from standby, converter fast or slow
    task automatic t_convert(input logic [1:0] kind, input int d);
        mcp_host_model_i.delay = d;
        mcp_host_model_i.send(kind, 1'h0);
        wait_state(ST_SETTLE, 0);
        check({state, ref_on, adc_on}, {ST_SETTLE, 2'h2});
        wait_state(ST_MEASURE, 300);
        check(n >= REF_SETTLE_CYC, 1'h1);
        check({state, ref_on, adc_on, conv_start}, {ST_MEASURE, 3'h7});
        wait_state(ST_STANDBY, d + 5);
        check({state, ref_on, adc_on}, {ST_STANDBY, 2'h0});
    endtask

    task automatic t_ref_up;
        mcp_host_model_i.delay = 3;
        mcp_host_model_i.send(CMD_WRITE_CONFIG_GROUP_A, 1'h1);
        wait_state(ST_REF_UP, 300);
        check(state, ST_REF_UP);
        check({ref_on, adc_on, keep_on}, 3'h5);
        mcp_host_model_i.send(CMD_CONVERT, 1'h0);
        wait_state(ST_MEASURE, 0);
        check({state, conv_start}, {ST_MEASURE, 1'h1});
        wait_state(ST_REF_UP, 20);
        check({state, adc_on}, {ST_REF_UP, 1'h0});
        mcp_host_model_i.send(CMD_WRITE_CONFIG_GROUP_A, 1'h0);
        wait_state(ST_STANDBY, 3);
        check({state, keep_on}, {ST_STANDBY, 1'h0});
    endtask

    // Commands that must not move the core
    task automatic t_other;
        mcp_host_model_i.send(CMD_OTHER, 1'h0);
        repeat (3) @(posedge clk_sys);
        #1;
        check({state, ref_on}, {ST_STANDBY, 1'h0});
    endtask

    // Traffic holds off the watchdog; running discharge timer keeps standby
    task automatic t_timeout;
        repeat (3) begin
            repeat (700) @(posedge clk_sys);
            mcp_host_model_i.send(CMD_OTHER, 1'h0);
        end
        #1;
        check({state, wd_exp}, {ST_STANDBY, 1'h0});
        repeat (WD_CYC + 100) @(posedge clk_sys);
        #1;
        check({state, wd_exp}, {ST_STANDBY, 1'h1});
        @(posedge clk_sys);
        dis_exp <= 1'h1;
        wait_state(ST_SLEEP, 5);
        check(state, ST_SLEEP);
        check({ref_on, adc_on, idle, drive}, 4'h2);
        @(posedge clk_sys);
        dis_exp <= 1'h0;
    endtask

    // Discharge disabled: watchdog alone ends reference-up into sleep
    task automatic t_wd_only;
        t_wake();
        mcp_host_model_i.send(CMD_WRITE_CONFIG_GROUP_A, 1'h1);
        wait_state(ST_REF_UP, 300);
        check(state, ST_REF_UP);
        @(posedge clk_sys);
        dis_en <= 1'h0;
        wait_state(ST_SLEEP, WD_CYC + 300);
        check(n >= WD_CYC - REF_SETTLE_CYC - 20, 1'h1);
        check({state, keep_on}, {ST_SLEEP, 1'h0});
        // Plain standby with discharge disabled: watchdog alone ends it
        t_wake();
        wait_state(ST_SLEEP, WD_CYC + 20);
        check(n >= WD_CYC - 10, 1'h1);
        check(state, ST_SLEEP);
    endtask

    // Hang guard sized well above the expected run
    initial begin
        #(20000 * 20);
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'h1;
        #1;
        check(state, ST_SLEEP);
        check({ref_on, adc_on, idle, drive}, 4'h2);
        repeat (3) @(posedge clk_sys);
        t_wake();
        t_convert(CMD_CONVERT, 1);
        t_convert(CMD_DIAGNOSE, 60);
        t_ref_up();
        t_other();
        t_timeout();
        t_wd_only();
        test_done();
    end
endmodule
`default_nettype wire
